//--- common/dcadc_link_if.sv
// Serial link between the converter device and its host controller.
// Assumes a pull-up on the data line: it reads high while released.
`timescale 1ns/1ps
`default_nettype none
interface dcadc_link_if;
  logic sclk;
  logic cs_b;
  logic din;
  logic dout_drv;
  logic dout_oe_b;
  logic dout;

  // Released line reads as the pull-up level
  assign dout = dout_oe_b ? 1'b1 : dout_drv;

  modport device (
    input sclk,
    input cs_b,
    input din,
    output dout_drv,
    output dout_oe_b
  );

  modport host (
    output sclk,
    output cs_b,
    output din,
    input dout
  );
endinterface : dcadc_link_if
`default_nettype wire

//--- common/dcadc_pkg.sv
// Constants shared by both ends of the two-channel converter serial link.
// Assumes a 40 MHz host clock and a host-made serial clock of at most 5 MHz.
//
// Summary of operation
// - Conversion completes within sixteen serial clock periods.
// - Host leaves data released 30 ns before restarting.
// - Host waits 1 us after wake-up.
// - Host starts at most 250 thousand conversions/second.
// - Device drives data only after frame select falls.
// - Device launches each result bit after falling clock.
// - Channel-select bits captured on falling clock edges.
// - Device releases data after final falling edge.
// - Host lowers frame select before any clocking.
// - Word: two zeros, id, id, twelve bits MSB-first.
// - Third shifted-in bit selects channel converted in the next frame.
package dcadc_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int RES_W = 12;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h10;
  localparam logic [CNT_W-1:0] EDGE_CAPTURE = 5'h01;
  localparam logic [CNT_W-1:0] EDGE_CHAN_SEL = 5'h03;
  localparam logic [CNT_W-1:0] SLOT_ID = 5'h02;
  localparam logic [CNT_W-1:0] SLOT_ID_REP = 5'h03;
  localparam logic [CNT_W-1:0] SLOT_DATA0 = 5'h04;
  localparam int CHAN_POS = 13;
  localparam int ID_POS = 13;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SCLK_MAX_KHZ = 5000;
  localparam int SCLK_MIN_PERIOD_PS = 1000000000 / SCLK_MAX_KHZ;
  localparam int HALF_CYC = (SCLK_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RELINQUISH_NS = 30;
  localparam int INTER_CONVERSION_GAP_NS = 30;
  localparam int GAP_CYC = ((RELINQUISH_NS + INTER_CONVERSION_GAP_NS) * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int WAKE_US = 1;
  localparam int WAKE_CYC = (WAKE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MAX_RATE_KSPS = 250;
  localparam int FRAME_MIN_CYC = (1000000000 / MAX_RATE_KSPS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TIM_W = 8;

endpackage : dcadc_pkg

//--- hw/dcadc_device.sv
// Device end: serial shifter and channel decode of the two-channel converter.
// Assumes the converter core holds both result inputs stable while a frame runs.
`timescale 1ns/1ps
`default_nettype none
module dcadc_device
  import dcadc_pkg::*;
(
  // Link side
  dcadc_link_if.device LINK,
  // User side
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic [dcadc_pkg::RES_W-1:0] CH0_RESULT_I,
  input wire logic [dcadc_pkg::RES_W-1:0] CH1_RESULT_I,
  output logic FRAME_START_O,
  output logic CONV_CHAN_O
);
  import dcadc_pkg::*;

  // ****************************************************************
  // Link domain: frame state, cleared while frame select is high
  // ****************************************************************
  typedef struct packed {
    logic [CNT_W-1:0] edges;
    logic conv_chan;
    logic [RES_W-1:0] result;
    logic dout;
    logic start_tgl;
  } dcadc_frame_type;

  localparam dcadc_frame_type FRAME_RST = '0;

  dcadc_frame_type frame_q;
  dcadc_frame_type frame_d;
  logic chan_sel_q;
  logic chan_sel_d;
  logic tgl_keep_q;
  logic rst_l1_q;
  logic rst_l2_q;

  // Frame select high clears the frame without any clock edge, so the
  // stopped serial clock can never leave a stale count behind.
  always_comb begin
    frame_d = frame_q;
    chan_sel_d = chan_sel_q;
    if (frame_q.edges != FRAME_EDGES) begin
      frame_d.edges = frame_q.edges + 5'h01;
      if (frame_d.edges == EDGE_CAPTURE) begin
        frame_d.conv_chan = chan_sel_q;
        frame_d.result = chan_sel_q ? CH1_RESULT_I : CH0_RESULT_I;
        frame_d.start_tgl = ~tgl_keep_q;
      end
      if (frame_d.edges == EDGE_CHAN_SEL) begin
        chan_sel_d = LINK.din;
      end
      // Next slot launched right after this falling edge
      if (frame_d.edges == SLOT_ID || frame_d.edges == SLOT_ID_REP) begin
        frame_d.dout = frame_d.conv_chan;
      end else if (frame_d.edges >= SLOT_DATA0 && frame_d.edges < FRAME_EDGES) begin
        frame_d.dout = frame_d.result[RES_W - 1 - 32'(frame_d.edges - SLOT_DATA0)];
      end else begin
        frame_d.dout = 1'b0;
      end
    end
    if (!CE_I) begin
      frame_d = frame_q;
      chan_sel_d = chan_sel_q;
    end
  end

  always_ff @(negedge LINK.sclk or posedge LINK.cs_b) begin
    if (LINK.cs_b) begin
      frame_q <= FRAME_RST;
    end else begin
      frame_q <= frame_d;
    end
  end

  // Start toggle must survive frame clears, so it is kept apart
  always_ff @(negedge LINK.sclk) begin
    rst_l1_q <= RST_B_I;
    rst_l2_q <= rst_l1_q;
    if (!rst_l2_q) begin
      chan_sel_q <= 1'b0;
      tgl_keep_q <= 1'b0;
    end else if (CE_I && !LINK.cs_b && frame_d.edges == EDGE_CAPTURE
                 && frame_q.edges != EDGE_CAPTURE) begin
      tgl_keep_q <= frame_d.start_tgl;
      chan_sel_q <= chan_sel_d;
    end else if (CE_I && !LINK.cs_b) begin
      chan_sel_q <= chan_sel_d;
    end
  end

  // Driven only inside a frame and before the last falling edge
  assign LINK.dout_oe_b = LINK.cs_b | (frame_q.edges == FRAME_EDGES);
  assign LINK.dout_drv = frame_q.dout;

  // ****************************************************************
  // User domain: frame start event and converted channel
  // ****************************************************************
  typedef struct packed {
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic chan_s1;
    logic chan_s2;
    logic start;
    logic chan;
  } dcadc_user_type;

  dcadc_user_type user_q;
  dcadc_user_type user_d;

  always_comb begin
    user_d = user_q;
    user_d.tgl_s1 = tgl_keep_q;
    user_d.tgl_s2 = user_q.tgl_s1;
    user_d.tgl_s3 = user_q.tgl_s2;
    user_d.chan_s1 = chan_sel_q;
    user_d.chan_s2 = user_q.chan_s1;
    user_d.start = user_q.tgl_s2 ^ user_q.tgl_s3;
    if (user_d.start) begin
      user_d.chan = user_q.chan_s2;
    end
    if (!CE_I) begin
      user_d = user_q;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      user_q <= '0;
    end else begin
      user_q <= user_d;
    end
  end

  assign FRAME_START_O = user_q.start;
  assign CONV_CHAN_O = user_q.chan;
endmodule : dcadc_device
`default_nettype wire

//--- hw/dcadc_host.sv
// Host end: makes the serial clock by division, frames conversions, collects results.
// Assumes the device end of the link interface and a pull-up on the data line.
`timescale 1ns/1ps
`default_nettype none
module dcadc_host
  import dcadc_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  // Link side
  dcadc_link_if.host LINK,
  // Request
  input wire logic START_I,
  input wire logic CHAN_I,
  input wire logic WAKE_I,
  output logic READY_O,
  // Result
  output logic RESULT_VALID_O,
  output logic [dcadc_pkg::RES_W-1:0] RESULT_O,
  output logic RESULT_CHAN_O
);
  import dcadc_pkg::*;

  typedef enum logic [2:0] {
    ST_WAKE,
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_TAIL
  } dcadc_state_type;

  typedef struct packed {
    dcadc_state_type state;
    logic [TIM_W-1:0] div;
    logic [TIM_W-1:0] period;
    logic [TIM_W-1:0] wait_cnt;
    logic [CNT_W-1:0] falls;
    logic [WORD_W-1:0] tx;
    logic [WORD_W-1:0] rx;
    logic sclk;
    logic cs_b;
    logic dout_s1;
    logic dout_s2;
    logic valid;
    logic [RES_W-1:0] result;
    logic chan;
  } dcadc_host_type;

  localparam logic [TIM_W-1:0] HALF_LAST = TIM_W'(HALF_CYC - 1);
  localparam logic [TIM_W-1:0] GAP_LAST = TIM_W'(GAP_CYC - 1);
  localparam logic [TIM_W-1:0] WAKE_LAST = TIM_W'(WAKE_CYC - 1);
  localparam logic [TIM_W-1:0] FRAME_LAST = TIM_W'(FRAME_MIN_CYC - 1);

  dcadc_host_type q;
  dcadc_host_type d;

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.dout_s1 = LINK.dout;
    d.dout_s2 = q.dout_s1;
    if (q.period != FRAME_LAST) begin
      d.period = q.period + 8'h01;
    end
    case (q.state)
      ST_WAKE: begin
        d.wait_cnt = q.wait_cnt + 8'h01;
        if (q.wait_cnt == WAKE_LAST) begin
          d.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        d.wait_cnt = '0;
        if (WAKE_I) begin
          d.state = ST_WAKE;
        end else if (START_I && q.period == FRAME_LAST) begin
          d.state = ST_SETUP;
          d.cs_b = 1'b0;
          d.period = '0;
          d.div = '0;
          d.falls = '0;
          d.tx = '0;
          d.tx[CHAN_POS] = CHAN_I;
        end
      end
      ST_SETUP: begin
        d.div = q.div + 8'h01;
        if (q.div == HALF_LAST) begin
          d.rx = {q.rx[WORD_W-2:0], q.dout_s2};
          d.sclk = 1'b0;
          d.falls = q.falls + 5'h01;
          d.div = '0;
          d.state = ST_LOW;
        end
      end
      ST_LOW: begin
        d.div = q.div + 8'h01;
        if (q.div == HALF_LAST) begin
          d.sclk = 1'b1;
          d.div = '0;
          if (q.falls == FRAME_EDGES) begin
            d.cs_b = 1'b1;
            d.state = ST_TAIL;
            d.valid = 1'b1;
            d.result = q.rx[RES_W-1:0];
            d.chan = q.rx[ID_POS];
          end else begin
            d.tx = {q.tx[WORD_W-2:0], 1'b0};
            d.state = ST_HIGH;
          end
        end
      end
      ST_HIGH: begin
        d.div = q.div + 8'h01;
        if (q.div == HALF_LAST) begin
          d.rx = {q.rx[WORD_W-2:0], q.dout_s2};
          d.sclk = 1'b0;
          d.falls = q.falls + 5'h01;
          d.div = '0;
          d.state = ST_LOW;
        end
      end
      ST_TAIL: begin
        // Released line must stay quiet before the next frame
        d.wait_cnt = q.wait_cnt + 8'h01;
        if (q.wait_cnt == GAP_LAST) begin
          d.state = ST_IDLE;
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    if (!CE_I) begin
      d = q;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      q <= '{state: ST_WAKE, div: '0, period: FRAME_LAST, wait_cnt: '0, falls: '0,
             tx: '0, rx: '0, sclk: 1'b1, cs_b: 1'b1, dout_s1: 1'b1, dout_s2: 1'b1,
             valid: 1'b0, result: '0, chan: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign LINK.sclk = q.sclk;
  assign LINK.cs_b = q.cs_b;
  assign LINK.din = q.tx[WORD_W-1];
  assign READY_O = (q.state == ST_IDLE) && (q.period == FRAME_LAST);
  assign RESULT_VALID_O = q.valid;
  assign RESULT_O = q.result;
  assign RESULT_CHAN_O = q.chan;
endmodule : dcadc_host
`default_nettype wire

//--- tb/dcadc_checker.sv
// Link checks between the converter device and host ends.
// Assumes sclk and cs_b change only just after rising edges of CLOCK_I.
`timescale 1ns/1ps
`default_nettype none
module dcadc_checker (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // Link
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic din,
  input wire logic dout_drv,
  input wire logic dout_oe_b,
  input wire logic dout,
  // Host request side
  input wire logic wake
);
  // ****************
  // Helper counters
  // ****************
  logic [4:0] nfall_q;
  logic [7:0] since_q;
  logic [5:0] wake_q;
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      nfall_q <= 5'h00;
      since_q <= 8'hff;
      // Saturated: only a wake request seen by this checker restarts the wait
      wake_q <= 6'h3f;
    end else begin
      nfall_q <= cs_b ? 5'h00 : nfall_q + {4'h0, $fell(sclk)};
      since_q <= $fell(cs_b) ? 8'h00 : since_q + {7'h00, since_q != 8'hff};
      wake_q <= wake ? 6'h00 : wake_q + {5'h00, wake_q != 6'h3f};
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  // ****************
  // Checks
  // ****************
  a_idle_released: assert property (cs_b |-> dout_oe_b)
    else $error("data driven outside frame");
  a_frame_drives: assert property ($fell(cs_b) |-> !dout_oe_b)
    else $error("data not driven at frame start");
  a_bit_launch: assert property (!dout_oe_b && $past(!dout_oe_b) && !$fell(sclk)
    |-> $stable(dout_drv)) else $error("data changed away from falling clock");
  a_release_last: assert property ($fell(sclk) && nfall_q == 5'h0f |-> dout_oe_b)
    else $error("data not released after last fall");
  a_sixteen_falls: assert property ($rose(cs_b) |-> nfall_q == 5'h10)
    else $error("frame did not hold sixteen falls");
  a_lead_zeros: assert property ($fell(cs_b) || ($fell(sclk) && nfall_q == 5'h00)
    |-> !dout) else $error("leading bit not zero");
  a_id_repeat: assert property ($fell(sclk) && nfall_q == 5'h02
    |-> dout == $past(dout, 8)) else $error("identifier not repeated");
  a_din_held: assert property ($fell(sclk) |-> $stable(din) ##1 $stable(din))
    else $error("select bit moved at falling clock");
  a_frame_first: assert property ($fell(sclk) |-> !$past(cs_b, 4))
    else $error("clock fell too soon after frame start");
  a_quiet_gap: assert property ($rose(cs_b) |=> cs_b [*3])
    else $error("quiet gap too short");
  a_rate_limit: assert property ($fell(cs_b) |-> since_q >= 8'h9f)
    else $error("frames started too close");
  a_wake_wait: assert property (!cs_b |-> wake_q >= 6'h28)
    else $error("frame started during wake wait");
  cover property ($rose(cs_b));
  cover property ($fell(sclk) && nfall_q == 5'h0f);
  cover property ($fell(cs_b) && since_q == 8'hff);
  cover property ($fell(cs_b) && wake_q != 6'h3f);
endmodule : dcadc_checker
`default_nettype wire

//--- tb/dual_channel_adc_serial_port_tb_top.sv
// Bench joining host and device ends over one link interface.
// Assumes the package constants and the link pull-up of the interface.
`timescale 1ns/1ps
`default_nettype none
module dual_channel_adc_serial_port_tb_top;
  import dcadc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic dev_rst_b = 1'b0;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic chan = 1'b0;
  logic wake = 1'b0;
  logic [RES_W-1:0] res0 = 12'h000;
  logic [RES_W-1:0] res1 = 12'h000;
  logic fstart, conv_chan, ready, valid, rchan, prev_sel;
  logic [RES_W-1:0] result;
  int n_mismatch = 0;
  int checked = 0;
  int fs_cnt = 0;
  always #12.5 clk = ~clk;
  always @(negedge clk) if (fstart === 1'b1) fs_cnt++;
  dcadc_link_if dcadc_link_if_i ();
  dcadc_host dcadc_host_i (.CLOCK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
    .LINK(dcadc_link_if_i), .START_I(start), .CHAN_I(chan), .WAKE_I(wake),
    .READY_O(ready), .RESULT_VALID_O(valid), .RESULT_O(result), .RESULT_CHAN_O(rchan));
  dcadc_device dcadc_device_i (.LINK(dcadc_link_if_i), .CLOCK_I(clk), .RST_B_I(dev_rst_b),
    .CE_I(ce), .CH0_RESULT_I(res0), .CH1_RESULT_I(res1), .FRAME_START_O(fstart),
    .CONV_CHAN_O(conv_chan));
  dcadc_checker dcadc_checker_i (.CLOCK_I(clk), .RST_B_I(dev_rst_b),
    .sclk(dcadc_link_if_i.sclk), .cs_b(dcadc_link_if_i.cs_b), .din(dcadc_link_if_i.din),
    .dout_drv(dcadc_link_if_i.dout_drv), .dout_oe_b(dcadc_link_if_i.dout_oe_b),
    .dout(dcadc_link_if_i.dout), .wake(wake));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_ready();
    int t;
    t = 0;
    while (ready !== 1'b1 && t < 400) begin
      @(negedge clk);
      t++;
    end
    if (ready !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] ready expected 1 seen %b", ready);
    end
  endtask : wait_ready

  // One frame; the word on the wire is gathered just after frame select falls and after each of the next 15 falling clocks
  task automatic conv(input logic ch, input bit judge);
    logic [15:0] w;
    logic [RES_W-1:0] exp;
    int fs0;
    int t;
    fs0 = fs_cnt;
    t = 0;
    wait_ready();
    start = 1'b1;
    chan = ch;
    @(negedge clk);
    start = 1'b0;
    if (dcadc_link_if_i.cs_b !== 1'b0) @(negedge dcadc_link_if_i.cs_b);
    #1 w[15] = dcadc_link_if_i.dout;
    for (int k = 14; k >= 0; k--) begin
      @(negedge dcadc_link_if_i.sclk);
      #1 w[k] = dcadc_link_if_i.dout;
    end
    while (valid !== 1'b1 && t < 200) begin
      @(negedge clk);
      t++;
    end
    if (valid !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] result valid expected 1 seen %b", valid);
    end
    exp = prev_sel ? res1 : res0;
    if (judge) begin
      chk("wire word", {2'b00, prev_sel, prev_sel, exp}, w);
      chk("result", {4'h0, exp}, {4'h0, result});
      chk("result chan", {15'h0000, prev_sel}, {15'h0000, rchan});
      chk("conv chan", {15'h0000, prev_sel}, {15'h0000, conv_chan});
      chk("frame starts", 16'h0001, 16'(fs_cnt - fs0));
    end
    prev_sel = ch;
  endtask : conv

  task automatic t_channels();
    logic [RES_W-1:0] v [5] = '{12'hfff, 12'h000, 12'h5a3, 12'ha5c, 12'h801};
    logic [4:0] sel = 5'b01101;
    for (int i = 0; i < 5; i++) begin
      res0 = v[i];
      res1 = ~v[i];
      conv(sel[i], 1'b1);
    end
    $display("channels done");
  endtask : t_channels

  task automatic t_refuse();
    logic seen;
    seen = 1'b0;
    conv(1'b0, 1'b1);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (170) begin
      @(negedge clk);
      if (valid === 1'b1) seen = 1'b1;
    end
    chk("refused start", 16'h0000, {15'h0000, seen});
    $display("refuse done");
  endtask : t_refuse

  task automatic t_wake();
    int t;
    t = 0;
    wait_ready();
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    chk("ready after wake", 16'h0000, {15'h0000, ready});
    while (ready !== 1'b1 && t < 100) begin
      @(negedge clk);
      t++;
    end
    chk("wake wait", 16'h0001, {15'h0000, t >= 38 && t <= 41});
    conv(1'b1, 1'b1);
    $display("wake done");
  endtask : t_wake

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // Device reset spans a first frame so its select register settles to zero.
  // Its release needs two serial clock falls, so a second frame goes unjudged.
  initial begin
    prev_sel = 1'b0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    conv(1'b0, 1'b0);
    repeat (4) @(negedge clk);
    dev_rst_b = 1'b1;
    conv(1'b0, 1'b0);
    t_channels();
    t_refuse();
    t_wake();
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule : dual_channel_adc_serial_port_tb_top
`default_nettype wire
